// ### rtl/buzzer_drive.sv
`timescale 1ns/1ps
`default_nettype none
module buzzer_drive
	import gpio_port_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Sources
	input wire logic softOn,
	input wire logic buzzerReq_n,
	// Drive
	output logic buzzerOn
);

	logic onQ, onD;

	always_comb begin
		onD = softOn | ~buzzerReq_n;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			onQ <= CONTROL_RESET[BUZZER_BIT];
		end else if (clkEn) begin
			onQ <= onD;
		end
	end

	assign buzzerOn = onQ;

endmodule : buzzer_drive
`default_nettype wire

// ### rtl/gpio_beeper_backlight_port.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_beeper_backlight_port
	import gpio_port_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Module address page
	input wire logic [7:0] modulePage,
	// Host bus
	input wire logic busSel,
	input wire logic busWr,
	input wire logic [7:0] busPage,
	input wire logic [15:0] busAddr,
	input wire logic [7:0] busWdata,
	output logic [7:0] busRdata,
	output logic busAck,
	// Pins
	input wire logic [3:0] bidirLinesIn,
	input wire logic [3:0] inputOnlyLinesIn,
	output logic [3:0] bidirLinesOut,
	output logic [3:0] bidirLinesOe,
	input wire logic buzzerReq_n,
	output logic buzzerOn,
	output logic backlightOn
);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	bus_req_s req;
	reg_sel_e target;
	logic hit;
	logic [7:0] controlQ, controlD, dataQ, dataD, dirQ, dirD;
	logic [7:0] rdataQ, rdataD;
	logic ackQ, ackD, backQ, backD;
	logic [7:0] pinRead;

	always_comb begin
		req = '{sel: busSel, wr: busWr, page: busPage, addr: busAddr, wdata: busWdata};
		hit = req.sel && req.page == modulePage && (req.addr & WINDOW_MASK) == WINDOW_BASE;
		target = hit ? decode(req.addr) : REG_NONE;
		controlD = controlQ;
		dataD = dataQ;
		dirD = dirQ;
		rdataD = rdataQ;
		ackD = hit;
		if (hit && req.wr) begin
			if (target == REG_CONTROL) begin
				controlD = req.wdata;
			end else if (target == REG_DATA) begin
				dataD = req.wdata;
			end else if (target == REG_DIRECTION) begin
				dirD = req.wdata;
			end
		end else if (hit) begin
			if (target == REG_CONTROL) begin
				rdataD = controlQ;
			end else if (target == REG_DATA) begin
				// Output bits come from the latch itself, so a read right after a write sees the new value.
				rdataD = {pinRead[7:4], dirQ[DIRECTION_BIT] ? dataQ[3:0] : pinRead[3:0]};
			end else if (target == REG_DIRECTION) begin
				rdataD = dirQ;
			end else begin
				rdataD = 8'h00;
			end
		end
		backD = controlD[BACKLIGHT_BIT];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			controlQ <= CONTROL_RESET;
			dataQ <= DATA_RESET;
			dirQ <= DIRECTION_RESET;
			rdataQ <= RDATA_RESET;
			ackQ <= 1'b0;
			backQ <= CONTROL_RESET[BACKLIGHT_BIT];
		end else if (clkEn) begin
			controlQ <= controlD;
			dataQ <= dataD;
			dirQ <= dirD;
			rdataQ <= rdataD;
			ackQ <= ackD;
			backQ <= backD;
		end
	end

	assign busRdata = rdataQ;
	assign busAck = ackQ;
	assign backlightOn = backQ;

	// ----------------------------------------
	// Pins and buzzer
	// ----------------------------------------
	gpio_pin_io pinIo (
		.mclk(mclk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.dataLatch(dataQ),
		.outputMode(dirQ[DIRECTION_BIT]),
		.bidirLinesIn(bidirLinesIn),
		.inputOnlyLinesIn(inputOnlyLinesIn),
		.bidirLinesOut(bidirLinesOut),
		.bidirLinesOe(bidirLinesOe),
		.readValue(pinRead)
	);

	buzzer_drive buzzer (
		.mclk(mclk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.softOn(controlQ[BUZZER_BIT]),
		.buzzerReq_n(buzzerReq_n),
		.buzzerOn(buzzerOn)
	);

endmodule : gpio_beeper_backlight_port
`default_nettype wire

// ### rtl/gpio_pin_io.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_io
	import gpio_port_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Register state
	input wire logic [7:0] dataLatch,
	input wire logic outputMode,
	// Pins
	input wire logic [3:0] bidirLinesIn,
	input wire logic [3:0] inputOnlyLinesIn,
	output logic [3:0] bidirLinesOut,
	output logic [3:0] bidirLinesOe,
	output logic [7:0] readValue
);

	logic [3:0] outQ, outD, oeQ, oeD;
	logic [7:0] rdQ, rdD;

	always_comb begin
		outD = dataLatch[3:0];
		oeD = {4{outputMode}};
		rdD[3:0] = outputMode ? dataLatch[3:0] : bidirLinesIn;
		rdD[7:4] = inputOnlyLinesIn;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			outQ <= DATA_RESET[3:0];
			oeQ <= {4{DIRECTION_RESET[DIRECTION_BIT]}};
			rdQ <= RDATA_RESET;
		end else if (clkEn) begin
			outQ <= outD;
			oeQ <= oeD;
			rdQ <= rdD;
		end
	end

	assign bidirLinesOut = outQ;
	assign bidirLinesOe = oeQ;
	assign readValue = rdQ;

endmodule : gpio_pin_io
`default_nettype wire

// ### rtl/gpio_port_pkg.sv
// Overview of operation
// - Byte window at 0xC000 on selected page.
// - Eight lines map to data byte 0xC00D.
// - Bits 0-3 bidirectional, switched as one nibble.
// - Bits 4-7 are input only, never driven.
// - Bit 0 of 0xC00E sets nibble direction.
// - Direction bit clears at reset, nibble inputs.
// - Data write updates latch, outputs drive it.
// - Output bits read back the latch.
// - Input bits read the pin level.
// - Control bit 0 switches the buzzer.
// - Control bit 1 switches the backlight.
// - All three bytes are writable and readable.
// - Low buzzer request line also sounds buzzer.
`default_nettype none
package gpio_port_pkg;

	// ----------------------------------------
	// Address map
	// ----------------------------------------
	localparam logic [15:0] WINDOW_BASE = 16'hc000;
	localparam logic [15:0] WINDOW_MASK = 16'hfff0;
	localparam logic [7:0] PAGE_DEFAULT = 8'h00;
	localparam logic [15:0] CONTROL_OFFSET = 16'hc002;
	localparam logic [15:0] DATA_OFFSET = 16'hc00d;
	localparam logic [15:0] DIRECTION_OFFSET = 16'hc00e;

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int BUZZER_BIT = 0;
	localparam int BACKLIGHT_BIT = 1;
	localparam int DIRECTION_BIT = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] DIRECTION_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	typedef struct packed {
		logic sel;
		logic wr;
		logic [7:0] page;
		logic [15:0] addr;
		logic [7:0] wdata;
	} bus_req_s;

	typedef enum logic [1:0] {
		REG_NONE,
		REG_CONTROL,
		REG_DATA,
		REG_DIRECTION
	} reg_sel_e;

	function automatic reg_sel_e decode(input logic [15:0] addr);
		if (addr == CONTROL_OFFSET) begin
			return REG_CONTROL;
		end else if (addr == DATA_OFFSET) begin
			return REG_DATA;
		end else if (addr == DIRECTION_OFFSET) begin
			return REG_DIRECTION;
		end else begin
			return REG_NONE;
		end
	endfunction : decode

endpackage : gpio_port_pkg
`default_nettype wire

// ### tb/gpio_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [7:0] modulePage,
	input wire logic busSel,
	input wire logic busWr,
	input wire logic [7:0] busPage,
	input wire logic [15:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic [7:0] busRdata,
	input wire logic busAck,
	input wire logic [3:0] inputOnlyLinesIn,
	input wire logic [3:0] bidirLinesOut,
	input wire logic [3:0] bidirLinesOe,
	input wire logic buzzerReq_n,
	input wire logic buzzerOn,
	input wire logic backlightOn
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire logic hit = clkEn && busSel && busPage == modulePage && busAddr[15:4] == 12'hc00;
	sequence wrAt(logic [15:0] a);
		hit && busWr && busAddr == a ##1 clkEn && !busSel;
	endsequence
	ack_hit_a: assert property (hit |=> busAck)
		else $error("no ack on hit");
	miss_quiet_a: assert property (clkEn && !hit |=> !busAck)
		else $error("ack without hit");
	dir_oe_a: assert property (wrAt(16'hc00e) |=>
		bidirLinesOe == ($past(busWdata[0], 2) ? 4'hf : 4'h0))
		else $error("enable differs from direction");
	latch_out_a: assert property (wrAt(16'hc00d) |=> bidirLinesOut == $past(busWdata[3:0], 2))
		else $error("latch not on pins");
	light_on_a: assert property (hit && busWr && busAddr == 16'hc002 |=> backlightOn == $past(busWdata[1]))
		else $error("backlight wrong");
	buzzer_ctl_a: assert property (wrAt(16'hc002) |=>
		buzzerOn == ($past(busWdata[0], 2) || !$past(buzzerReq_n)))
		else $error("buzzer wrong");
	buzzer_req_a: assert property (clkEn && !buzzerReq_n |=> buzzerOn)
		else $error("buzzer request ignored");
	read_inputs_a: assert property (hit && !busWr && busAddr == 16'hc00d &&
		$past(clkEn) && $stable(inputOnlyLinesIn) |=> busRdata[7:4] == $past(inputOnlyLinesIn))
		else $error("input bits wrong");
	read_latch_a: assert property (hit && !busWr && busAddr == 16'hc00d |=>
		bidirLinesOe != 4'hf || busRdata[3:0] == bidirLinesOut)
		else $error("output bits not read from latch");
endmodule : gpio_port_checker
bind gpio_beeper_backlight_port gpio_port_checker i_chk (.*);
`default_nettype wire

// ### tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
	import gpio_port_pkg::*;
(
	input wire logic mclk,
	input wire logic [7:0] busRdata,
	input wire logic busAck,
	output var bus_req_s req
);
	int seed = 64;
	initial req = '0;
	// One access after a random idle gap; got stays low when no ack came.
	task automatic xfer(input logic w, input logic [23:0] a, input logic [7:0] d, output logic [7:0] q, output logic got);
		got = 1'b0;
		q = 8'h00;
		repeat (1 + ($unsigned($random(seed)) % 3)) @(negedge mclk);
		req = '{1'b1, w, a[23:16], a[15:0], d};
		for (int i = 0; i < 4 && !got; i++) begin
			@(negedge mclk);
			req.sel = 1'b0;
			got = busAck;
			q = busRdata;
		end
	endtask : xfer
	task automatic rmw(input logic [23:0] a, input logic [7:0] m, input logic v, output logic got);
		logic [7:0] q;
		logic g;
		xfer(1'b0, a, 8'h00, q, g);
		xfer(1'b1, a, v ? q | m : q & ~m, q, got);
		got = got & g;
	endtask : rmw
endmodule : host_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import gpio_port_pkg::*;
	logic mclk = 0, rst_n = 0, clkEn = 1, buzzerReq_n = 1, busAck, buzzerOn, backlightOn, got;
	logic [7:0] pins = 8'h00, modulePage = 8'h00, busRdata, q;
	logic [3:0] bidirLinesOut, bidirLinesOe;
	wire logic [3:0] pad = bidirLinesOe & bidirLinesOut | ~bidirLinesOe & pins[3:0];
	bus_req_s req;
	int n_fail = 0, check_count = 0, seed = 64, ctl, dir = 0, lat;
	host_model i_host (.mclk(mclk), .busRdata(busRdata), .busAck(busAck), .req(req));
	gpio_beeper_backlight_port i_dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .modulePage(modulePage),
		.busSel(req.sel), .busWr(req.wr), .busPage(req.page), .busAddr(req.addr), .busWdata(req.wdata),
		.busRdata(busRdata), .busAck(busAck), .bidirLinesIn(pad), .inputOnlyLinesIn(pins[7:4]),
		.bidirLinesOut(bidirLinesOut), .bidirLinesOe(bidirLinesOe), .buzzerReq_n(buzzerReq_n),
		.buzzerOn(buzzerOn), .backlightOn(backlightOn));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic stop_test;
		if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		i_host.xfer(w, {8'h00, a}, d, q, got);
		if (got !== 1'b1) begin
			n_fail++;
			stop_test();
		end
	endtask : acc
	initial forever #12.5 mclk = ~mclk;
	initial begin
		repeat (8) @(negedge mclk);
		rst_n = 1;
		acc(0, 16'hc00e, 0);
		chk(q, 8'h00);
		for (int i = 0; i < 4; i++) begin
			ctl = i;
			acc(1, 16'hc002, ctl[7:0]);
			repeat (2) @(negedge mclk);
			chk({6'h00, buzzerOn, backlightOn}, {6'h00, ctl[0], ctl[1]});
			acc(0, 16'hc002, 0);
			chk(q, ctl[7:0]);
		end
		for (int i = 0; i < 24; i++) begin
			if (i % 8 == 4) begin
				i_host.rmw(24'h00c00e, 8'h01, !dir[0], got);
				chk({7'h00, got}, 8'h01);
				dir = dir ^ 1;
			end
			lat = $random(seed);
			pins = 8'($random(seed));
			acc(1, 16'hc00d, lat[7:0]);
			repeat (3) @(negedge mclk);
			chk({bidirLinesOe, bidirLinesOut}, {{4{dir[0]}}, lat[3:0]});
			acc(0, 16'hc00d, 0);
			chk(q, {pins[7:4], dir[0] ? lat[3:0] : pins[3:0]});
		end
		i_host.xfer(0, 24'h01c00d, 0, q, got);
		chk({7'h00, got}, 8'h00);
		i_host.xfer(0, 24'h00c10d, 0, q, got);
		chk({7'h00, got}, 8'h00);
		buzzerReq_n = 0;
		acc(1, 16'hc002, 0);
		repeat (3) @(negedge mclk);
		chk({7'h00, buzzerOn}, 8'h01);
		clkEn = 0;
		buzzerReq_n = 1;
		repeat (3) @(negedge mclk);
		chk({7'h00, buzzerOn}, 8'h01);
		clkEn = 1;
		repeat (3) @(negedge mclk);
		chk({7'h00, buzzerOn}, 8'h00);
		modulePage = 8'h03;
		i_host.xfer(0, 24'h03c00e, 0, q, got);
		chk({7'h00, got}, 8'h01);
		chk(q, {7'h00, dir[0]});
		i_host.xfer(0, 24'h03c000, 0, q, got);
		chk({7'h00, got}, 8'h01);
		chk(q, 8'h00);
		i_host.xfer(0, 24'h00c00e, 0, q, got);
		chk({7'h00, got}, 8'h00);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
